// file: rtl/sensor_cpu_shift_branch_mul_exec.sv
`timescale 1ns/10ps
module sensor_cpu_shift_branch_mul_exec
	import sensor_cpu_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        instr_valid,
	input  wire logic [7:0]  instr_byte,
	output logic             instr_ready,
	output logic [15:0]      pc_out,
	input  wire logic        load_valid,
	input  wire load_req_t   load_req,
	output logic             load_ready,
	input  wire logic [3:0]  view_sel,
	output logic [15:0]      view_reg_data,
	output logic [15:0]      view_port_data
);

	logic [15:0] rf_reg [16];
	logic [15:0] port_reg [16];
	logic [15:0] pc_reg;
	exec_state_t state_reg;
	logic [3:0]  mul_count_reg;
	logic [4:0]  busy_run_reg;

	instr_t      ins;
	logic        accept;
	logic        load_go;
	logic [15:0] sel_val;
	logic [15:0] acc;
	logic [15:0] mcand;
	logic [15:0] mplier;
	logic [15:0] idx;
	logic        mplier_msb;
	logic [15:0] result;
	logic        writes_dest;
	logic        branch_taken;
	logic        is_branch;
	logic        mul_start;
	logic [31:0] mul_next;
	logic [31:0] mul_ref;
	logic [15:0] pc_next;

	// Shift-and-add step; the accumulator holds the running high word.
	function automatic logic [31:0] mul_step(input logic [15:0] a, input logic [15:0] m,
		input logic [15:0] n);
		logic [16:0] s;
		s = {1'b0, a} + (m[0] ? {1'b0, n} : 17'h00000);
		return {s, m[15:1]};
	endfunction : mul_step

	assign ins = instr_t'(instr_byte);
	assign instr_ready = (state_reg == ST_IDLE);
	assign accept = instr_valid && instr_ready;
	assign load_ready = (state_reg == ST_IDLE) && !instr_valid;
	assign load_go = load_valid && load_ready;
	assign pc_out = pc_reg;

	// Register zero is the program pointer itself.
	assign sel_val = (ins.sel == pointer_sel) ? pc_reg : rf_reg[ins.sel];
	assign acc = rf_reg[accumulator_sel];
	assign mcand = rf_reg[multiplicand_reg];
	assign mplier = rf_reg[multiplier_reg];
	assign idx = rf_reg[index_test_reg];
	assign mplier_msb = mplier[15];

	always_comb
	begin
		result = sel_val;
		writes_dest = 1'b1;
		unique case (ins.op)
			shift_left_op:
			begin
				result = {sel_val[14:0], (ins.sel == shift_link_reg) ? mplier_msb : 1'b0};
			end
			arith_shift_right_op: result = {sel_val[15], sel_val[15:1]};
			increment_op: result = sel_val + PC_STEP;
			decrement_op: result = sel_val - PC_STEP;
			invert_op: result = ~sel_val;
			default: writes_dest = 1'b0;
		endcase
	end

	always_comb
	begin
		is_branch = 1'b0;
		branch_taken = 1'b0;
		if (ins.op == branch_nonnegative_op)
		begin
			is_branch = 1'b1;
			branch_taken = !idx[15];
		end
		else if (ins.op == branch_nonzero_op)
		begin
			is_branch = 1'b1;
			branch_taken = (idx != WORD_ZERO);
		end
	end

	always_comb
	begin
		if (is_branch && branch_taken)
			pc_next = pc_reg + sel_val;
		else if (writes_dest && ins.sel == pointer_sel)
			pc_next = result;
		else
			pc_next = pc_reg + PC_STEP;
	end

	// Other register nibbles under the multiply opcode are executed as a plain step.
	assign mul_start = accept && ins.op == multiply_op && ins.sel == multiply_sel;
	assign mul_next = mul_step(acc, mplier, mcand);
	assign mul_ref = {16'h0000, mcand} * {16'h0000, mplier};

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			for (int i = 0; i < 16; i++)
				rf_reg[i] <= WORD_RESET;
		end
		else if (accept)
		begin
			if (writes_dest && ins.sel != pointer_sel)
				rf_reg[ins.sel] <= result;
			if (ins.op == port_read_op)
				rf_reg[accumulator_sel] <= port_reg[ins.sel];
			if (mul_start)
			begin
				rf_reg[accumulator_sel] <= mul_next[31:16];
				rf_reg[multiplier_reg] <= mul_next[15:0];
			end
		end
		else if (state_reg == ST_MULTIPLY)
		begin
			rf_reg[accumulator_sel] <= mul_next[31:16];
			rf_reg[multiplier_reg] <= mul_next[15:0];
		end
		else if (load_go && !load_req.to_port && load_req.sel != pointer_sel)
			rf_reg[load_req.sel] <= load_req.data;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			for (int i = 0; i < 16; i++)
				port_reg[i] <= WORD_RESET;
		end
		else if (accept && ins.op == port_write_op)
			port_reg[ins.sel] <= acc;
		else if (load_go && load_req.to_port)
			port_reg[load_req.sel] <= load_req.data;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
			pc_reg <= PC_RESET;
		else if (accept && !mul_start)
			pc_reg <= pc_next;
		else if (state_reg == ST_MULTIPLY && mul_count_reg == MUL_COUNT_LAST)
			pc_reg <= pc_reg + PC_STEP;
		else if (load_go && !load_req.to_port && load_req.sel == pointer_sel)
			pc_reg <= load_req.data;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			state_reg <= ST_IDLE;
			mul_count_reg <= MUL_COUNT_RESET;
		end
		else
		begin
			unique case (state_reg)
				ST_IDLE:
				begin
					if (mul_start)
					begin
						state_reg <= ST_MULTIPLY;
						mul_count_reg <= MUL_COUNT_FIRST;
					end
				end
				ST_MULTIPLY:
				begin
					mul_count_reg <= mul_count_reg + MUL_COUNT_STEP;
					if (mul_count_reg == MUL_COUNT_LAST)
						state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			view_reg_data <= WORD_RESET;
			view_port_data <= WORD_RESET;
		end
		else
		begin
			view_reg_data <= (view_sel == pointer_sel) ? pc_reg : rf_reg[view_sel];
			view_port_data <= port_reg[view_sel];
		end
	end

	// Counts consecutive busy cycles so that the multiply stall length can be checked.
	// busy cycle count
	always_ff @(posedge clock)
	begin
		if (rst || instr_ready)
			busy_run_reg <= 5'h00;
		else
			busy_run_reg <= busy_run_reg + 5'h01;
	end

	AST_SHL: assert property (@(posedge clock) disable iff (rst)
		accept && ins.op == shift_left_op && ins.sel != shift_link_reg && ins.sel != pointer_sel
		|=> rf_reg[$past(ins.sel)] == ($past(sel_val) << 1))
		else $error("left shift result wrong");

	AST_SHL_LINK: assert property (@(posedge clock) disable iff (rst)
		accept && ins.op == shift_left_op && ins.sel == shift_link_reg
		|=> rf_reg[shift_link_reg] == {$past(sel_val[14:0]), $past(mplier_msb)}
		&& mplier == $past(mplier))
		else $error("linked left shift wrong");

	AST_SHR: assert property (@(posedge clock) disable iff (rst)
		accept && ins.op == arith_shift_right_op && ins.sel != pointer_sel
		|=> rf_reg[$past(ins.sel)] == {$past(sel_val[15]), $past(sel_val[15:1])})
		else $error("arithmetic right shift wrong");

	AST_INC: assert property (@(posedge clock) disable iff (rst)
		accept && ins.op == increment_op && ins.sel != pointer_sel
		|=> rf_reg[$past(ins.sel)] == 16'($past(sel_val) + 16'h0001))
		else $error("increment wrong");

	AST_DEC: assert property (@(posedge clock) disable iff (rst)
		accept && ins.op == decrement_op && ins.sel != pointer_sel
		|=> rf_reg[$past(ins.sel)] == 16'($past(sel_val) - 16'h0001))
		else $error("decrement wrong");

	AST_INV: assert property (@(posedge clock) disable iff (rst)
		accept && ins.op == invert_op && ins.sel != pointer_sel
		|=> (rf_reg[$past(ins.sel)] ^ $past(sel_val)) == 16'hFFFF)
		else $error("invert wrong");

	AST_BPOS: assert property (@(posedge clock) disable iff (rst)
		accept && ins.op == branch_nonnegative_op
		|=> pc_reg == 16'($past(pc_reg) + ($past(idx[15]) ? 16'h0001 : $past(sel_val))))
		else $error("nonnegative branch target wrong");

	AST_BNZ: assert property (@(posedge clock) disable iff (rst)
		accept && ins.op == branch_nonzero_op
		|=> pc_reg == 16'($past(pc_reg) + (($past(idx) == 16'h0000) ? 16'h0001
		: $past(sel_val))))
		else $error("nonzero branch target wrong");

	AST_RD: assert property (@(posedge clock) disable iff (rst)
		accept && ins.op == port_read_op
		|=> acc == $past(port_reg[ins.sel])
		&& port_reg[$past(ins.sel)] == $past(port_reg[ins.sel]))
		else $error("port read wrong");

	AST_WR: assert property (@(posedge clock) disable iff (rst)
		accept && ins.op == port_write_op
		|=> port_reg[$past(ins.sel)] == $past(acc) && acc == $past(acc))
		else $error("port write wrong");

	AST_MUL: assert property (@(posedge clock) disable iff (rst)
		mul_start && acc == 16'h0000
		|=> ##15 instr_ready && busy_run_reg == 5'(MUL_CYCLES - 1)
		&& {acc, mplier} == $past(mul_ref, 16)
		&& mcand == $past(mcand, 16) && pc_reg == 16'($past(pc_reg, 16) + 16'h0001))
		else $error("multiply result or timing wrong");

	AST_BUSY: assert property (@(posedge clock) disable iff (rst)
		!instr_ready |-> busy_run_reg < 5'(MUL_CYCLES - 1))
		else $error("multiply stall too long");

	AST_STEP: assert property (@(posedge clock) disable iff (rst)
		accept && writes_dest && ins.sel != pointer_sel
		|=> instr_ready && pc_reg == 16'($past(pc_reg) + 16'h0001) && acc == ($past(ins.sel)
		== accumulator_sel ? acc : $past(acc)))
		else $error("single cycle op stepped wrongly");

endmodule : sensor_cpu_shift_branch_mul_exec

// file: inc/sensor_cpu_pkg.sv
package sensor_cpu_pkg;

	localparam logic [3:0]  shift_left_op          = 4'h6;
	localparam logic [3:0]  arith_shift_right_op   = 4'h7;
	localparam logic [3:0]  increment_op           = 4'h8;
	localparam logic [3:0]  decrement_op           = 4'h9;
	localparam logic [3:0]  invert_op              = 4'hA;
	localparam logic [3:0]  branch_nonnegative_op  = 4'hB;
	localparam logic [3:0]  branch_nonzero_op      = 4'hC;
	localparam logic [3:0]  port_read_op           = 4'hD;
	localparam logic [3:0]  port_write_op          = 4'hE;
	localparam logic [3:0]  multiply_op            = 4'hF;
	localparam logic [3:0]  multiply_sel           = 4'h3;

	localparam logic [3:0]  pointer_sel            = 4'h0;
	localparam logic [3:0]  accumulator_sel        = 4'h1;
	localparam logic [3:0]  multiplicand_reg       = 4'h3;
	localparam logic [3:0]  multiplier_reg         = 4'h4;
	localparam logic [3:0]  index_test_reg         = 4'h5;
	localparam logic [3:0]  shift_link_reg         = 4'h6;

	localparam logic [15:0] WORD_RESET             = 16'h0000;
	localparam logic [15:0] PC_RESET               = 16'h0000;
	localparam logic [15:0] PC_STEP                = 16'h0001;
	localparam logic [15:0] WORD_ZERO              = 16'h0000;
	localparam int          MUL_CYCLES             = 16;
	localparam logic [3:0]  MUL_COUNT_FIRST        = 4'h1;
	localparam logic [3:0]  MUL_COUNT_LAST         = 4'(MUL_CYCLES - 1);
	localparam logic [3:0]  MUL_COUNT_RESET        = 4'h0;
	localparam logic [3:0]  MUL_COUNT_STEP         = 4'h1;

	typedef enum logic {ST_IDLE, ST_MULTIPLY} exec_state_t;

	typedef struct packed {
		logic [3:0] op;
		logic [3:0] sel;
	} instr_t;

	typedef struct packed {
		logic        to_port;
		logic [3:0]  sel;
		logic [15:0] data;
	} load_req_t;

endpackage : sensor_cpu_pkg

// file: verification/program_flash_model.sv
`timescale 1ns/10ps
module program_flash_model
(
	input  wire logic        clock,
	input  wire logic        fetch_en,
	input  wire logic [15:0] pc_out,
	output logic             instr_valid,
	output logic [7:0]       instr_byte
);
	logic [7:0] mem [256];

	// While not fetching the byte lines carry a pattern that moves with the pointer.
	assign instr_valid = fetch_en;
	assign instr_byte  = fetch_en ? mem[pc_out[7:0]] : (pc_out[7:0] ^ 8'hA5);
endmodule : program_flash_model

// file: verification/sensor_cpu_shift_branch_mul_exec_tb.sv
`timescale 1ns/10ps
module sensor_cpu_shift_branch_mul_exec_tb
	import sensor_cpu_pkg::*;
();
	logic        clock, rst, instr_valid, instr_ready, load_valid, load_ready, fetch_en;
	logic [7:0]  instr_byte;
	logic [15:0] pc_out, view_reg_data, view_port_data, epc;
	logic [3:0]  view_sel;
	load_req_t   load_req;
	logic [15:0] er [16];
	logic [15:0] ep [16];
	logic [31:0] seed;
	int          failures, checked;

	sensor_cpu_shift_branch_mul_exec DUT
	(
		.clock(clock), .rst(rst), .instr_valid(instr_valid), .instr_byte(instr_byte),
		.instr_ready(instr_ready), .pc_out(pc_out), .load_valid(load_valid),
		.load_req(load_req), .load_ready(load_ready), .view_sel(view_sel),
		.view_reg_data(view_reg_data), .view_port_data(view_port_data)
	);

	program_flash_model flash
	(
		.clock(clock), .fetch_en(fetch_en), .pc_out(pc_out), .instr_valid(instr_valid),
		.instr_byte(instr_byte)
	);

	initial
	begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	task automatic complete_run();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : complete_run

	task automatic cmp(input logic [15:0] got, input logic [15:0] want);
		checked++;
		if (got !== want)
		begin
			failures++;
			$display("unexpected at %0t: got %h want %h", $time, got, want);
		end
	endtask : cmp

	task automatic wait_high(input int which, output int n);
		n = 0;
		while (((which == 1) ? load_ready : instr_ready) !== 1'b1 && n < 40)
		begin
			@(posedge clock);
			#2;
			n++;
		end
		if (n == 40)
		begin
			failures++;
			complete_run();
		end
	endtask : wait_high

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	// Reference behaviour of one accepted instruction byte.
	function automatic void step(input logic [7:0] b);
		logic [3:0]  op;
		logic [3:0]  s;
		logic [15:0] x;
		logic [15:0] r;
		logic [31:0] p;
		op = b[7:4];
		s = b[3:0];
		x = (s == 4'h0) ? epc : er[s];
		p = er[multiplicand_reg] * er[multiplier_reg];
		case (op)
			shift_left_op: r = {x[14:0], (s == shift_link_reg) & er[multiplier_reg][15]};
			arith_shift_right_op: r = {x[15], x[15:1]};
			increment_op: r = x + 16'h0001;
			decrement_op: r = x - 16'h0001;
			invert_op: r = ~x;
			default: r = 16'h0000;
		endcase
		if ((op == branch_nonnegative_op && !er[index_test_reg][15]) ||
			(op == branch_nonzero_op && er[index_test_reg] != 16'h0000))
			epc = epc + x;
		else if (op >= shift_left_op && op <= invert_op && s == 4'h0)
			epc = r;
		else
			epc = epc + 16'h0001;
		if (op >= shift_left_op && op <= invert_op && s != 4'h0)
			er[s] = r;
		if (op == port_read_op)
			er[accumulator_sel] = ep[s];
		if (op == port_write_op)
			ep[s] = er[accumulator_sel];
		if (op == multiply_op && s == multiply_sel)
		begin
			er[accumulator_sel] = p[31:16];
			er[multiplier_reg] = p[15:0];
		end
	endfunction : step

	task automatic load(input logic tp, input logic [3:0] s, input logic [15:0] d);
		int n;
		fetch_en = 1'b0;
		@(posedge clock);
		#2;
		load_valid = 1'b1;
		load_req = {tp, s, d};
		#1;
		wait_high(1, n);
		@(posedge clock);
		#2;
		load_valid = 1'b0;
		if (tp)
			ep[s] = d;
		else if (s == 4'h0)
			epc = d;
		else
			er[s] = d;
	endtask : load

	task automatic issue(input logic [7:0] b);
		int n;
		flash.mem[pc_out[7:0]] = b;
		fetch_en = 1'b1;
		#1;
		cmp({15'h0000, load_ready}, 16'h0000);
		wait_high(0, n);
		@(posedge clock);
		#2;
		step(b);
		wait_high(0, n);
		cmp(16'(n), (b == 8'hF3) ? 16'h000F : 16'h0000);
		cmp(pc_out, epc);
	endtask : issue

	task automatic check_all();
		fetch_en = 1'b0;
		for (int i = 0; i < 16; i++)
		begin
			view_sel = 4'(i);
			@(posedge clock);
			#2;
			cmp(view_reg_data, (i == 0) ? epc : er[i]);
			cmp(view_port_data, ep[i]);
		end
	endtask : check_all

	initial
	begin
		rst = 1'b1;
		fetch_en = 1'b0;
		load_valid = 1'b0;
		load_req = '0;
		view_sel = 4'h0;
		failures = 0;
		checked = 0;
		seed = 32'hC63D0942;
		epc = 16'h0000;
		for (int i = 0; i < 16; i++)
		begin
			er[i] = 16'h0000;
			ep[i] = 16'h0000;
		end
		repeat (16) @(posedge clock);
		#2;
		rst = 1'b0;
		check_all();
		load(1'b0, 4'h2, 16'hFFFF);
		issue(8'h82);
		issue(8'h92);
		load(1'b0, multiplier_reg, 16'h8001);
		load(1'b0, shift_link_reg, 16'h4000);
		issue(8'h66);
		issue(8'h62);
		issue(8'h72);
		issue(8'hA6);
		issue(8'h76);
		load(1'b0, index_test_reg, 16'h8000);
		issue(8'hB2);
		issue(8'hC2);
		load(1'b0, index_test_reg, 16'h0000);
		issue(8'hC2);
		issue(8'hB2);
		load(1'b1, 4'h9, 16'hBEEF);
		issue(8'hD9);
		issue(8'hE7);
		load(1'b0, multiplicand_reg, 16'hFFFF);
		load(1'b0, multiplier_reg, 16'hFFFF);
		load(1'b0, accumulator_sel, 16'h0000);
		issue(8'hF3);
		issue(8'hF5);
		issue(8'h81);
		check_all();
		for (int k = 0; k < 300; k++)
		begin
			seed = lfsr(seed);
			if (seed[7:4] < shift_left_op && seed[8])
				load(seed[9], seed[3:0], seed[31:16]);
			else
			begin
				if (seed[7:0] == 8'hF3)
					load(1'b0, accumulator_sel, 16'h0000);
				issue(seed[7:0]);
			end
		end
		check_all();
		complete_run();
	end
endmodule : sensor_cpu_shift_branch_mul_exec_tb
